// ===== src/serial_channel_status_async_tx.sv
`default_nettype none
// How it works
// R1: latch three-bit residue code at frame end
// R2: async all-sent when buffer and shifter empty
// R3: sync or HDLC without length mode: all-sent one
// R4: HDLC length mode: flags set, CRC clears
// R5: vector status returns programmed vector normally
// R6: status-vector substitutes source code in bus-mode bits
// R7: highest pending source; none pending gives ones
// R8: fixed source codes, B then A
// R9: length mode counts transmitted characters
// R10: counter clears on reset, match, reload
// R11: underrun mismatch sends abort, freezes counter
// R12: two command writes load length low, high
// R13: host loads length before enabling transmitter
// R14: request held off after length reached
// R15: start, parity, stop framing; idle mark
// R16: rate field divides bit clock 1/16/32/64
// R17: length code 00=5,01=7,10=6,11=8
// R18: stop bits and parity select
// R19: terminal-ready, break, enable, request-to-send bits
// R20: host programs format register first
// R21: start on falling clock edge, LSB first
// R22: buffer-empty status and request; mark when done
// R23: auto-enable waits for clear-to-send low
module serial_channel_status_async_tx
  import serial_channel_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic transmit_bit_clock,
  input wire logic clear_to_send_n,
  input wire serial_channel_pkg::framer_evt_t framer_evt,
  input wire logic [7:0] pending_sources,
  output logic serial_out,
  output logic terminal_ready_n,
  output logic request_to_send_n,
  output logic transmit_request_output,
  output logic status_change_pulse,
  output logic abort_request
);
  import serial_channel_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Character length code to data bits
  function automatic logic [3:0] char_bits(input logic [1:0] code);
    case (code)
      2'h0: char_bits = 4'h5;
      2'h1: char_bits = 4'h7;
      2'h2: char_bits = 4'h6;
      default: char_bits = 4'h8;
    endcase
  endfunction

  // Rate code to bit-clock falling edges per bit
  function automatic logic [6:0] rate_div(input logic [1:0] code);
    case (code)
      2'h0: rate_div = 7'h01;
      2'h1: rate_div = 7'h10;
      2'h2: rate_div = 7'h20;
      default: rate_div = 7'h40;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] int_ctrl_r;
  logic [7:0] vec_ctrl_r;
  logic [7:0] rx_ctrl_r;
  logic [7:0] clk_fmt_r;
  logic [7:0] tx_ctrl_r;
  logic [7:0] mode_r;
  logic [7:0] tx_buf_r;
  logic buf_full_r;
  logic [15:0] len_r;
  logic [15:0] count_r;
  logic [1:0] load_phase_r;
  logic count_done_r;
  logic frozen_r;
  logic hdlc_sent_r;
  logic [2:0] residue_r;
  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic clk_prev_r;
  logic [6:0] edge_cnt_r;
  logic [8:0] shift_r;
  logic [3:0] bits_left_r;
  logic line_r;
  tx_state_t state_r;
  logic serial_out_r;
  logic dtr_n_r;
  logic rts_n_r;
  logic txreq_r;
  logic es_pulse_r;
  logic abort_r;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // A request completes at the edge where waitrequest is low
  wire req = read | write;
  wire do_wr = write & ~waitrequest_r;
  wire wr_int = do_wr & (address == ADDR_INT_CTRL);
  wire wr_cmd = do_wr & (address == ADDR_COMMAND);
  wire wr_data = do_wr & (address == ADDR_TX_DATA);
  wire [7:0] wbyte = writedata[7:0];
  wire len_set = wr_int & wbyte[IC_LEN_MODE];

  // ------------------------------------------------------------
  // Derived controls
  // ------------------------------------------------------------
  tx_cfg_t cfg;
  assign cfg = '{rate: clk_fmt_r[7:6], stop: clk_fmt_r[3:2], par_even: clk_fmt_r[1],
                 par_en: clk_fmt_r[0], len: tx_ctrl_r[6:5]};
  frame_mode_t fmode;
  assign fmode = frame_mode_t'(mode_r[1:0]);
  wire len_mode = int_ctrl_r[IC_LEN_MODE];
  wire tx_en = tx_ctrl_r[TC_TX_EN];
  wire [6:0] div = rate_div(cfg.rate); // see R16
  wire [6:0] half = (div == 7'h01) ? 7'h01 : (div >> 1);
  wire [6:0] stop_len = (cfg.stop == STOP_ONE) ? div :
                        (cfg.stop == STOP_ONE_HALF) ? 7'(div + half) :
                        7'(div << 1); // see R18
  wire fall = clk_prev_r & ~transmit_bit_clock; // see R21
  wire bit_end = fall & ((state_r == TX_STOP) ? (edge_cnt_r == 7'(stop_len - 7'h01)) :
                                               (edge_cnt_r == 7'(div - 7'h01)));
  wire cts_ok = ~rx_ctrl_r[RC_AUTO_EN] | ~clear_to_send_n; // see R23
  wire can_start = tx_en & buf_full_r & cts_ok & fall; // see R21
  wire [3:0] nbits = char_bits(cfg.len); // see R17
  wire [7:0] dmask = 8'(9'h0FF >> (4'h8 - nbits));
  wire [7:0] dbits = tx_buf_r & dmask; // see R21
  wire par_bit = cfg.par_even ? (^dbits) : ~(^dbits); // see R18
  wire [8:0] frame = cfg.par_en ? (9'(dbits) | (9'(par_bit) << nbits)) : 9'(dbits);
  wire [3:0] frame_bits = 4'(nbits + {3'h0, cfg.par_en});
  wire idle_next = (state_r == TX_IDLE) & ~can_start;
  wire start_now = can_start & ((state_r == TX_IDLE) | ((state_r == TX_STOP) & bit_end));
  wire count_en = len_mode & ~frozen_r & ~count_done_r & start_now; // see R9
  wire count_hit = count_en & (16'(count_r + 16'h0001) == len_r); // see R10
  wire mismatch = framer_evt.underrun & (fmode == MODE_HDLC) & len_mode & ~frozen_r
                  & (count_r != len_r); // see R11
  wire async_sent = ~buf_full_r & (state_r == TX_IDLE); // see R2
  wire all_sent = (fmode == MODE_ASYNC) ? async_sent :
                  (len_mode & (fmode == MODE_HDLC)) ? hdlc_sent_r : 1'b1; // see R3

  // Highest code wins among pending sources
  logic [2:0] top_code;
  always_comb
  begin
    top_code = NO_PENDING_CODE; // see R7
    for (int i = 0; i < 8; i++)
    begin
      if (pending_sources[i])
      begin
        top_code = 3'(i); // see R8
      end
    end
  end
  wire any_pend = |pending_sources;
  wire [2:0] sub_code = any_pend ? top_code : NO_PENDING_CODE; // see R7
  wire subst = int_ctrl_r[IC_STAT_VEC]; // see R5
  wire [7:0] vec_bus1 = {vec_ctrl_r[7:5], sub_code, vec_ctrl_r[1:0]};
  wire [7:0] vec_bus2 = {vec_ctrl_r[7:3], sub_code};
  wire [7:0] vec_stat = ~subst ? vec_ctrl_r :
                        (mode_r[MD_BUS_MODE] ? vec_bus2 : vec_bus1); // see R6

  // Read data selection
  logic [7:0] rmux;
  always_comb
  begin
    case (address)
      ADDR_INT_CTRL: rmux = int_ctrl_r;
      ADDR_VEC_CTRL: rmux = vec_ctrl_r;
      ADDR_RX_CTRL: rmux = rx_ctrl_r;
      ADDR_CLK_FMT: rmux = clk_fmt_r;
      ADDR_TX_CTRL: rmux = tx_ctrl_r;
      ADDR_MODE: rmux = mode_r;
      ADDR_PRIMARY: rmux = {5'h00, ~buf_full_r, 2'h0}; // see R22
      ADDR_RX_ERR: rmux = {4'h0, residue_r, all_sent}; // see R1
      ADDR_VEC_STAT: rmux = vec_stat; // see R5
      ADDR_CNT_LOW: rmux = count_r[7:0]; // see R9
      ADDR_CNT_HIGH: rmux = count_r[15:8];
      default: rmux = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Bus slave: one wait state on every access
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h0000_0000;
    end
    else
    begin
      waitrequest_r <= ~(req & waitrequest_r);
      if (read & waitrequest_r)
      begin
        readdata_r <= {24'h00_0000, rmux};
      end
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      int_ctrl_r <= RST_CTRL;
      vec_ctrl_r <= RST_CTRL;
      rx_ctrl_r <= RST_CTRL;
      clk_fmt_r <= RST_CTRL;
      tx_ctrl_r <= RST_CTRL;
      mode_r <= RST_CTRL;
    end
    else if (do_wr)
    begin
      case (address)
        ADDR_INT_CTRL: int_ctrl_r <= wbyte;
        ADDR_VEC_CTRL: vec_ctrl_r <= wbyte;
        ADDR_RX_CTRL: rx_ctrl_r <= wbyte; // see R23
        ADDR_CLK_FMT: clk_fmt_r <= wbyte; // see R16
        ADDR_TX_CTRL: tx_ctrl_r <= wbyte; // see R19
        ADDR_MODE: mode_r <= wbyte;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Length load and character counter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      len_r <= RST_LEN;
      load_phase_r <= 2'h0;
      count_r <= RST_LEN;
      count_done_r <= 1'b0;
      frozen_r <= 1'b0;
      abort_r <= 1'b0;
    end
    else
    begin
      abort_r <= mismatch; // see R11
      if (len_set)
      begin
        load_phase_r <= 2'h2; // see R12
        count_r <= RST_LEN; // see R10
        count_done_r <= 1'b0; // see R14
        frozen_r <= mismatch; // A mismatch in the reload cycle still freezes, see R11
      end
      else
      begin
        if (wr_cmd & (load_phase_r == 2'h2))
        begin
          len_r[7:0] <= wbyte; // see R12
          load_phase_r <= 2'h1;
        end
        else if (wr_cmd & (load_phase_r == 2'h1))
        begin
          len_r[15:8] <= wbyte;
          load_phase_r <= 2'h0;
        end
        if (mismatch)
        begin
          frozen_r <= 1'b1; // see R11
        end
        if (count_hit)
        begin
          count_r <= RST_LEN; // see R10
          count_done_r <= 1'b1; // see R14
        end
        else if (count_en)
        begin
          count_r <= 16'(count_r + 16'h0001);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit buffer, frame status and residue
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tx_buf_r <= 8'h00;
      buf_full_r <= 1'b0;
      hdlc_sent_r <= 1'b1;
      residue_r <= 3'h0;
      es_pulse_r <= 1'b0;
    end
    else
    begin
      if (wr_data)
      begin
        tx_buf_r <= wbyte;
      end
      buf_full_r <= wr_data | (buf_full_r & ~start_now); // see R22
      if (framer_evt.frame_end)
      begin
        residue_r <= framer_evt.residue; // see R1
      end
      if (framer_evt.flags_done)
      begin
        hdlc_sent_r <= 1'b1; // see R4
      end
      else if (framer_evt.crc_sent)
      begin
        hdlc_sent_r <= 1'b0;
      end
      es_pulse_r <= framer_evt.flags_done & len_mode & (fmode == MODE_HDLC); // see R4
    end
  end

  // ------------------------------------------------------------
  // Transmit shifter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_r <= TX_IDLE;
      clk_prev_r <= 1'b1;
      edge_cnt_r <= 7'h00;
      shift_r <= 9'h000;
      bits_left_r <= 4'h0;
      line_r <= 1'b1;
    end
    else
    begin
      clk_prev_r <= transmit_bit_clock;
      if (start_now)
      begin
        state_r <= TX_SHIFT; // see R15
        line_r <= 1'b0;
        shift_r <= frame;
        bits_left_r <= frame_bits;
        edge_cnt_r <= 7'h00;
      end
      else if (bit_end & (state_r == TX_SHIFT))
      begin
        edge_cnt_r <= 7'h00;
        if (bits_left_r != 4'h0)
        begin
          line_r <= shift_r[0]; // see R21
          shift_r <= shift_r >> 1;
          bits_left_r <= 4'(bits_left_r - 4'h1);
        end
        else
        begin
          line_r <= 1'b1; // see R15
          state_r <= TX_STOP;
        end
      end
      else if (bit_end & (state_r == TX_STOP))
      begin
        state_r <= TX_IDLE; // see R22
        edge_cnt_r <= 7'h00;
      end
      else if (fall & (state_r != TX_IDLE))
      begin
        edge_cnt_r <= 7'(edge_cnt_r + 7'h01);
      end
      else if (idle_next)
      begin
        line_r <= 1'b1; // see R15
      end
    end
  end

  // ------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      serial_out_r <= 1'b1;
      dtr_n_r <= 1'b1;
      rts_n_r <= 1'b1;
      txreq_r <= 1'b0;
    end
    else
    begin
      serial_out_r <= line_r & ~tx_ctrl_r[TC_BREAK]; // see R19
      dtr_n_r <= ~tx_ctrl_r[TC_DTR]; // see R19
      rts_n_r <= ~tx_ctrl_r[TC_RTS] & all_sent; // see R19
      txreq_r <= tx_en & ~buf_full_r & ~wr_data & ~count_done_r & ~frozen_r; // see R14
    end
  end

  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign serial_out = serial_out_r;
  assign terminal_ready_n = dtr_n_r;
  assign request_to_send_n = rts_n_r;
  assign transmit_request_output = txreq_r;
  assign status_change_pulse = es_pulse_r;
  assign abort_request = abort_r;
endmodule // serial_channel_status_async_tx
`default_nettype wire

// ===== src/serial_channel_pkg.sv
`default_nettype none
package serial_channel_pkg;
  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_INT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_VEC_CTRL = 8'h08;
  localparam logic [7:0] ADDR_RX_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_CLK_FMT = 8'h10;
  localparam logic [7:0] ADDR_TX_CTRL = 8'h14;
  localparam logic [7:0] ADDR_TX_DATA = 8'h18;
  localparam logic [7:0] ADDR_PRIMARY = 8'h1C;
  localparam logic [7:0] ADDR_RX_ERR = 8'h20;
  localparam logic [7:0] ADDR_VEC_STAT = 8'h24;
  localparam logic [7:0] ADDR_CNT_LOW = 8'h28;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h2C;
  localparam logic [7:0] ADDR_MODE = 8'h30;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int IC_LEN_MODE = 6;
  localparam int IC_STAT_VEC = 2;
  localparam int RC_AUTO_EN = 5;
  localparam int TC_DTR = 7;
  localparam int TC_BREAK = 4;
  localparam int TC_TX_EN = 3;
  localparam int TC_RTS = 1;
  localparam int PS_TX_EMPTY = 2;
  localparam int RE_ALL_SENT = 0;
  localparam int MD_BUS_MODE = 2;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_LEN = 16'h0000;
  localparam logic [2:0] NO_PENDING_CODE = 3'h7;
  // ------------------------------------------------------------
  // Modes and encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_ASYNC = 2'h0,
    MODE_SYNC = 2'h1,
    MODE_HDLC = 2'h2
  } frame_mode_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_SHIFT = 3'h2,
    TX_STOP = 3'h4
  } tx_state_t;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] STOP_ONE_HALF = 2'h2;
  // Character framing as set by software
  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] stop;
    logic par_even;
    logic par_en;
    logic [1:0] len;
  } tx_cfg_t;
  // Events from the synchronous/HDLC framer of this channel
  typedef struct packed {
    logic flags_done;
    logic crc_sent;
    logic underrun;
    logic frame_end;
    logic [2:0] residue;
  } framer_evt_t;
endpackage
`default_nettype wire

// ===== verification/channel_props.sv
`default_nettype none
module channel_props
  import serial_channel_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic transmit_bit_clock,
  input wire serial_channel_pkg::framer_evt_t framer_evt,
  input wire logic serial_out,
  input wire logic terminal_ready_n,
  input wire logic status_change_pulse,
  input wire logic abort_request
);
  timeunit 1ns;
  timeprecision 100ps;
  // -----------------------------------------------------------
  // Port timing checks
  // -----------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer one cycle after request");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("wait state low too long");
  a_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_unmapped_zero: assert property (read && !waitrequest && address > ADDR_MODE
    |-> readdata == 32'h00000000) else $error("unmapped read not zero");
  a_dtr_follow: assert property (write && !waitrequest && address == ADDR_TX_CTRL
    |-> ##2 terminal_ready_n == !$past(writedata[7], 2)) else $error("terminal ready wrong");
  // Line changes only two cycles after a falling bit clock edge
  a_edge_aligned: assert property ($changed(serial_out) && !$past(write, 2)
    && !$past(write, 3) |-> $past(transmit_bit_clock, 3) && !$past(transmit_bit_clock, 2))
    else $error("line moved off bit clock edge");
  a_pulse_cause: assert property (status_change_pulse |-> $past(framer_evt.flags_done))
    else $error("status pulse without flags sent");
  a_abort_cause: assert property (abort_request |-> $past(framer_evt.underrun))
    else $error("abort without underrun");
endmodule // channel_props
`default_nettype wire

// ===== verification/remote_station.sv
`default_nettype none
module remote_station
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic serial_out,
  input wire logic listen,
  input wire logic [6:0] div,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic par_even,
  output logic transmit_bit_clock,
  output logic got,
  output logic got_ok,
  output logic [7:0] got_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] phase_r = 3'h0;
  logic [7:0] d;
  logic ok;
  logic p;
  int i;

  // Bit clock of eight core cycles
  always_ff @(posedge core_clk)
    phase_r <= phase_r + 3'h1;
  assign transmit_bit_clock = ~phase_r[2];

  // Receive one character, sampling mid bit, and judge its framing
  initial
  begin
    got = 1'b0;
    got_ok = 1'b0;
    got_data = 8'h00;
    forever
    begin
      @(posedge core_clk);
      if (!reset && listen && serial_out === 1'b0)
      begin
        repeat (div * 4) @(posedge core_clk);
        ok = (serial_out === 1'b0);
        d = 8'h00;
        p = !par_even;
        for (i = 0; i < nbits; i++)
        begin
          repeat (div * 8) @(posedge core_clk);
          d[i] = serial_out;
          p = p ^ serial_out;
        end
        if (par_en)
        begin
          repeat (div * 8) @(posedge core_clk);
          ok = ok && ((p ^ serial_out) === 1'b0);
        end
        repeat (div * 8) @(posedge core_clk);
        ok = ok && (serial_out === 1'b1);
        got_data <= d;
        got_ok <= ok;
        got <= 1'b1;
        @(posedge core_clk);
        got <= 1'b0;
      end
    end
  end
endmodule // remote_station
`default_nettype wire

// ===== verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import serial_channel_pkg::*;
  localparam logic [31:0] NIL = 32'h00000000;
  localparam logic [31:0] ONE = 32'h00000001;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic clear_to_send_n = 1'b0;
  framer_evt_t framer_evt = '0;
  logic [7:0] pending_sources = 8'h00;
  logic [31:0] readdata;
  logic waitrequest, transmit_bit_clock, serial_out, terminal_ready_n, request_to_send_n;
  logic transmit_request_output, status_change_pulse, abort_request, got, got_ok;
  logic [7:0] got_data, v, lfsr_s = 8'h58;
  logic listen = 1'b1;
  logic par_en = 1'b0;
  logic par_even = 1'b0;
  logic [6:0] div = 7'h01;
  logic [3:0] nbits = 4'h5;
  logic [31:0] rd_v;
  logic [31:0] rq[$];
  logic [8:0] cq[$];
  int fail_count = 0;
  int checked = 0;
  int n_abort = 0;
  int n_stat = 0;
  int i, m, r, k;

  always #12.5 core_clk = ~core_clk;

  serial_channel_status_async_tx serial_channel_status_async_tx_i (.core_clk(core_clk),
    .reset(reset), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .transmit_bit_clock(transmit_bit_clock),
    .clear_to_send_n(clear_to_send_n), .framer_evt(framer_evt),
    .pending_sources(pending_sources), .serial_out(serial_out),
    .terminal_ready_n(terminal_ready_n), .request_to_send_n(request_to_send_n),
    .transmit_request_output(transmit_request_output),
    .status_change_pulse(status_change_pulse), .abort_request(abort_request));
  remote_station remote_station_i (.core_clk(core_clk), .reset(reset), .serial_out(serial_out),
    .listen(listen), .div(div), .nbits(nbits), .par_en(par_en), .par_even(par_even),
    .transmit_bit_clock(transmit_bit_clock), .got(got), .got_ok(got_ok), .got_data(got_data));

  // -----------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------
  task automatic report_and_stop();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic give_up();
    fail_count++;
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] act);
    checked++;
    if (act !== exp)
    begin
      $display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
      fail_count++;
    end
  endtask

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= {24'h000000, d};
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (waitrequest === 1'b0) break;
    end
    rd_v = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 50) give_up();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    bus(1'b1, a, 8'h00);
  endtask

  task automatic send(input logic [7:0] d);
    int n;
    for (n = 0; n < 3000; n++)
    begin
      bus(1'b1, ADDR_PRIMARY, 8'h00);
      if (rd_v[PS_TX_EMPTY] === 1'b1) break;
    end
    if (n == 3000) give_up();
    cq.push_back({1'b1, d & (8'hFF >> (4'h8 - nbits))});
    bus(1'b0, ADDR_TX_DATA, d);
  endtask

  task automatic wait_rx();
    int n;
    for (n = 0; n < 20000 && cq.size() > 0; n++) @(posedge core_clk);
    if (n == 20000) give_up();
  endtask

  task automatic pulse(input logic [6:0] e);
    @(posedge core_clk);
    framer_evt <= framer_evt_t'(e);
    @(posedge core_clk);
    framer_evt <= framer_evt_t'(7'h00);
  endtask

  // Compare reads and received characters with the oldest note
  always @(posedge core_clk)
  begin
    if (read === 1'b1 && waitrequest === 1'b0 && rq.size() > 0)
      chk(rq.pop_front(), readdata);
    if (got === 1'b1)
      chk(cq.size() > 0 ? {23'h0, cq.pop_front()} : ~NIL, {23'h0, got_ok, got_data});
    if (abort_request === 1'b1) n_abort++;
    if (status_change_pulse === 1'b1) n_stat++;
  end

  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rd_chk(ADDR_VEC_STAT, NIL);
    rd_chk(ADDR_CNT_HIGH, NIL);
    rd_chk(ADDR_RX_ERR, ONE);
    bus(1'b0, ADDR_CNT_LOW, 8'h5A);
    rd_chk(ADDR_CNT_LOW, NIL);
    rd_chk(8'h3C, NIL);
    v = lfsr_s;
    bus(1'b0, ADDR_VEC_CTRL, v);
    rd_chk(ADDR_VEC_STAT, {24'h0, v});
    bus(1'b0, ADDR_INT_CTRL, 8'h04);
    for (m = 0; m < 2; m++)
    begin
      bus(1'b0, ADDR_MODE, m != 0 ? 8'h04 : 8'h00);
      pending_sources <= 8'h00;
      rd_chk(ADDR_VEC_STAT, {24'h0, m != 0 ? v | 8'h07 : v | 8'h1C});
      for (i = 0; i < 8; i++)
      begin
        lfsr_s = lfsr_next(lfsr_s);
        pending_sources <= (8'h01 << i) | (lfsr_s & ((8'h01 << i) - 8'h01));
        rd_chk(ADDR_VEC_STAT, {24'h0, m != 0 ? {v[7:3], i[2:0]} : {v[7:5], i[2:0], v[1:0]}});
      end
    end
    bus(1'b0, ADDR_INT_CTRL, 8'h00);
    bus(1'b0, ADDR_MODE, 8'h00);
    // Every rate and length, two characters back to back each
    for (r = 0; r < 4; r++)
    begin
      div = r == 0 ? 7'h01 : 7'h08 << r;
      nbits = r == 0 ? 4'h5 : r == 1 ? 4'h7 : r == 2 ? 4'h6 : 4'h8;
      par_en = r != 0;
      par_even = r[0];
      bus(1'b0, ADDR_CLK_FMT, {r[1:0], 2'h0, r == 3 ? 2'h3 : r == 2 ? 2'h2 : 2'h1, r[0], par_en});
      bus(1'b0, ADDR_TX_CTRL, {1'b0, r[1:0], 5'h08});
      for (k = 0; k < 2; k++)
      begin
        lfsr_s = lfsr_next(lfsr_s);
        send(lfsr_s);
      end
      wait_rx();
    end
    // Auto-enable holds the line until clear-to-send
    clear_to_send_n <= 1'b1;
    bus(1'b0, ADDR_RX_CTRL, 8'h20);
    send(8'hA6);
    repeat (200) @(posedge core_clk);
    chk(ONE, {31'h0, serial_out});
    chk(ONE, cq.size());
    clear_to_send_n <= 1'b0;
    wait_rx();
    bus(1'b0, ADDR_RX_CTRL, 8'h00);
    // Length mode counting and request hold-off
    bus(1'b0, ADDR_TX_CTRL, 8'h00);
    bus(1'b0, ADDR_CLK_FMT, 8'h04);
    div = 7'h01;
    nbits = 4'h5;
    par_en = 1'b0;
    bus(1'b0, ADDR_INT_CTRL, 8'h40);
    bus(1'b0, ADDR_COMMAND, 8'h02);
    bus(1'b0, ADDR_COMMAND, 8'h00);
    bus(1'b0, ADDR_TX_CTRL, 8'h08);
    repeat (3) @(posedge core_clk);
    chk(ONE, {31'h0, transmit_request_output});
    send(8'h15);
    wait_rx();
    rd_chk(ADDR_CNT_LOW, ONE);
    send(8'h0A);
    wait_rx();
    rd_chk(ADDR_CNT_LOW, NIL);
    chk(NIL, {31'h0, transmit_request_output});
    repeat (20) @(posedge core_clk);
    rd_chk(ADDR_RX_ERR, ONE);
    // Terminal ready, break and request to send
    listen = 1'b0;
    bus(1'b0, ADDR_TX_CTRL, 8'h92);
    repeat (4) @(posedge core_clk);
    chk(NIL, {29'h0, serial_out, terminal_ready_n, request_to_send_n});
    bus(1'b0, ADDR_TX_CTRL, 8'h00);
    repeat (4) @(posedge core_clk);
    chk(32'h00000007, {29'h0, serial_out, terminal_ready_n, request_to_send_n});
    listen = 1'b1;
    // All-sent in sync mode, framer events in HDLC mode
    bus(1'b0, ADDR_INT_CTRL, 8'h00);
    bus(1'b0, ADDR_MODE, 8'h01);
    rd_chk(ADDR_RX_ERR, ONE);
    bus(1'b0, ADDR_MODE, 8'h02);
    bus(1'b0, ADDR_INT_CTRL, 8'h40);
    bus(1'b0, ADDR_COMMAND, 8'h03);
    bus(1'b0, ADDR_COMMAND, 8'h00);
    lfsr_s = lfsr_next(lfsr_s);
    pulse({4'h5, lfsr_s[2:0]});
    rd_chk(ADDR_RX_ERR, {28'h0, lfsr_s[2:0], 1'b0});
    pulse(7'h40);
    rd_chk(ADDR_RX_ERR, {28'h0, lfsr_s[2:0], 1'b1});
    pulse(7'h10);
    repeat (3) @(posedge core_clk);
    chk(ONE, n_abort);
    chk(ONE, n_stat);
    report_and_stop();
  end
endmodule // tb_top

bind serial_channel_status_async_tx channel_props channel_props_i (.core_clk(core_clk),
  .reset(reset), .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .transmit_bit_clock(transmit_bit_clock),
  .framer_evt(framer_evt), .serial_out(serial_out), .terminal_ready_n(terminal_ready_n),
  .status_change_pulse(status_change_pulse), .abort_request(abort_request));
`default_nettype wire
